// [verilog/counter_gate_clock_select_irq.sv]
// Gate and clock selection, identifier and interrupt register for six counters
// Operation
// - The identifier register reads back a fixed 16-bit code and ignores writes.
// - Status bits 13..8 latch on their channel's event (B2 on 13 down to A0 on 8), write 1 clears.
// - A channel's event is the rising edge of that counter's output, one set per edge.
// - Enable bits 5..0 gate the channels (B2 on 5 down to A0 on 0), one enables.
// - Control bits 12..8 pick the gate: 31..16 port 2 pins, 15..2 clock bus, 1 high, 0 low.
`timescale 1ns/1ns

module counter_gate_clock_select_irq
(
	// Clock and reset
	input  wire logic                             ref_clk,
	input  wire logic                             rst_n,
	// Register port
	input  wire logic [tc_ctrl_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [tc_ctrl_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic      [tc_ctrl_pkg::DATA_W-1:0]   reg_rdata,
	// Selection sources
	input  wire logic [15:0]                      port2_in,
	input  wire logic [15:0]                      clock_bus,
	// Counter outputs, interrupt sources
	input  wire logic [tc_ctrl_pkg::NUM_CH-1:0]   cnt_out,
	// Selected gate and count clock per counter
	output logic      [tc_ctrl_pkg::NUM_CH-1:0]   cnt_gate,
	output logic      [tc_ctrl_pkg::NUM_CH-1:0]   cnt_clk,
	// Interrupt request
	output logic                                  irq
);

	localparam int NCH = tc_ctrl_pkg::NUM_CH;

	// Control register index of an address, NCH when not a control register
	function automatic logic [2:0] ctrl_index(input logic [tc_ctrl_pkg::ADDR_W-1:0] a);
		logic [tc_ctrl_pkg::ADDR_W-1:0] d;
		d = a - tc_ctrl_pkg::OFS_CTRL_A0;
		if (a < tc_ctrl_pkg::OFS_CTRL_A0 || a > tc_ctrl_pkg::OFS_CTRL_B2 || a[0])
			return 3'(NCH);
		return d[3:1];
	endfunction

	// Gate decode shared by all channels
	function automatic logic gate_pick(input logic [4:0] s, input logic [15:0] p2,
		input logic [15:0] cb);
		logic r;
		r = 1'b0;
		if (s >= tc_ctrl_pkg::GATE_P2_BASE)
			r = p2[s[3:0]];
		else if (s >= tc_ctrl_pkg::GATE_CB_BASE)
			r = cb[s[3:0]];
		else
			r = (s == tc_ctrl_pkg::GATE_HIGH);
		return r;
	endfunction

	// Clock decode shared by all channels
	function automatic logic clk_pick(input logic [3:0] s, input logic [15:0] cb,
		input logic tick);
		logic r;
		r = 1'b0;
		if (s == tc_ctrl_pkg::CLK_FIXED)
			r = tick;
		else if (s != tc_ctrl_pkg::CLK_RSVD)
			r = cb[s];
		return r;
	endfunction

	// Synchronisers; the first stage feeds only the second
	logic [15:0]     p2_m_r;
	logic [15:0]     p2_s_r;
	logic [15:0]     cb_m_r;
	logic [15:0]     cb_s_r;
	logic [NCH-1:0]  co_m_r;
	logic [NCH-1:0]  co_s_r;
	logic [NCH-1:0]  co_d_r;
	logic [NCH-1:0]  co_rise;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			p2_m_r <= 16'h0000;
			p2_s_r <= 16'h0000;
			cb_m_r <= 16'h0000;
			cb_s_r <= 16'h0000;
			co_m_r <= 6'h00;
			co_s_r <= 6'h00;
			co_d_r <= 6'h00;
		end
		else
		begin
			p2_m_r <= port2_in;
			p2_s_r <= p2_m_r;
			cb_m_r <= clock_bus;
			cb_s_r <= cb_m_r;
			co_m_r <= cnt_out;
			co_s_r <= co_m_r;
			co_d_r <= co_s_r;
		end
	end

	// Event is the positive transition only
	assign co_rise = co_s_r & ~co_d_r;

	// Fixed 5 MHz count tick as a one-cycle enable
	logic [tc_ctrl_pkg::TICK_W-1:0] tick_cnt_r;
	logic                           tick_r;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_r <= tc_ctrl_pkg::TICK_ZERO;
			tick_r     <= 1'b0;
		end
		else
		begin
			tick_r <= (tick_cnt_r == tc_ctrl_pkg::TICK_LAST);
			if (tick_cnt_r == tc_ctrl_pkg::TICK_LAST)
				tick_cnt_r <= tc_ctrl_pkg::TICK_ZERO;
			else
				tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end

	// Register decode
	logic               wr_int;
	logic [2:0]         wr_idx;
	tc_ctrl_pkg::ctrl_t wr_ctrl;

	// Field positions come from the carrier layout, not from bare bit numbers
	assign wr_ctrl = reg_wdata;
	assign wr_int = reg_wr && (reg_addr == tc_ctrl_pkg::OFS_INT);
	assign wr_idx = ctrl_index(reg_addr);

	// Control registers
	tc_ctrl_pkg::ctrl_t ctrl_r [NCH];

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
					ctrl_r[g] <= tc_ctrl_pkg::CTRL_RST;
				else if (reg_wr && wr_idx == 3'(g))
				begin
					ctrl_r[g]          <= tc_ctrl_pkg::CTRL_RST;
					ctrl_r[g].gate_sel <= wr_ctrl.gate_sel;
					ctrl_r[g].clk_sel  <= wr_ctrl.clk_sel;
				end
			end

			// Selected gate and clock, registered
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					cnt_gate[g] <= 1'b0;
					cnt_clk[g]  <= 1'b0;
				end
				else
				begin
					cnt_gate[g] <= gate_pick(ctrl_r[g].gate_sel, p2_s_r, cb_s_r);
					cnt_clk[g]  <= clk_pick(ctrl_r[g].clk_sel, cb_s_r, tick_r);
				end
			end
		end
	endgenerate

	// Interrupt enable and status
	logic [NCH-1:0] int_en_r;
	logic [NCH-1:0] int_st_r;
	logic [NCH-1:0] st_clr;

	assign st_clr = wr_int ? reg_wdata[tc_ctrl_pkg::ST_LSB +: NCH] : 6'h00;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			int_en_r <= tc_ctrl_pkg::INT_EN_RST;
		else if (wr_int)
			int_en_r <= reg_wdata[tc_ctrl_pkg::EN_LSB +: NCH];
	end

	// Set beats a same-cycle clear so no edge is lost
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			int_st_r <= tc_ctrl_pkg::INT_ST_RST;
		else
			int_st_r <= (int_st_r & ~st_clr) | co_rise;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(int_st_r & int_en_r);
	end

	// Read data stands one cycle after the strobe only
	logic [tc_ctrl_pkg::DATA_W-1:0] rd_nxt;
	logic [2:0]                     rd_idx;

	always_comb
	begin
		rd_idx = ctrl_index(reg_addr);
		rd_nxt = tc_ctrl_pkg::RDATA_RST;
		if (reg_addr == tc_ctrl_pkg::OFS_ID)
			rd_nxt = tc_ctrl_pkg::ID_CODE;
		else if (reg_addr == tc_ctrl_pkg::OFS_INT)
		begin
			rd_nxt[tc_ctrl_pkg::ST_LSB +: NCH] = int_st_r;
			rd_nxt[tc_ctrl_pkg::EN_LSB +: NCH] = int_en_r;
		end
		else if (rd_idx < 3'(NCH))
			rd_nxt = ctrl_r[rd_idx];
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= tc_ctrl_pkg::RDATA_RST;
		else if (reg_rd)
			reg_rdata <= rd_nxt;
		else
			reg_rdata <= tc_ctrl_pkg::RDATA_RST;
	end

	// Checks
	default clocking cb_chk @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	AST_ID_READ: assert property (
		reg_rd && reg_addr == tc_ctrl_pkg::OFS_ID |=> reg_rdata == tc_ctrl_pkg::ID_CODE)
		else $error("identifier read returned wrong code");

	AST_ST_SET: assert property (
		$rose(co_s_r[0]) |=> int_st_r[0] ##1 (irq || !$past(int_en_r[0])))
		else $error("channel 0 status did not latch on its edge");

	AST_ST_HOLD: assert property (
		!co_rise[1] && !st_clr[1] |=> int_st_r[1] == $past(int_st_r[1]))
		else $error("status bit changed without edge or clear");

	AST_ST_CLEAR: assert property (
		wr_int && reg_wdata[tc_ctrl_pkg::ST_LSB+5] && !co_rise[5] |=> !int_st_r[5])
		else $error("write one did not clear status bit");

	AST_ST_ONLY_EDGE: assert property (
		$rose(int_st_r[3]) |-> $past(co_s_r[3]) && !$past(co_d_r[3]))
		else $error("status set without a rising edge");

	AST_EN_MASK: assert property (
		int_en_r == 6'h00 |=> !irq)
		else $error("interrupt raised with all channels disabled");

	AST_EN_WRITE: assert property (
		wr_int |=> int_en_r == $past(reg_wdata[tc_ctrl_pkg::EN_LSB +: NCH]))
		else $error("enable bits not taken from the write");

	AST_GATE_FORCE: assert property (
		ctrl_r[1].gate_sel == tc_ctrl_pkg::GATE_HIGH |=> cnt_gate[1])
		else $error("forced high gate not high");

	AST_GATE_PORT2: assert property (
		ctrl_r[2].gate_sel == tc_ctrl_pkg::GATE_P2_BASE |=> cnt_gate[2] == $past(p2_s_r[0]))
		else $error("port 2 gate selection wrong");

	AST_GATE_CB: assert property (
		ctrl_r[3].gate_sel == tc_ctrl_pkg::GATE_CB_BASE |=> cnt_gate[3] == $past(cb_s_r[2]))
		else $error("clock bus gate selection wrong");

	// Tick idles two cycles after reset, so wait for it to settle
	AST_CLK_FIXED: assert property (
		(rst_n && ctrl_r[0].clk_sel == tc_ctrl_pkg::CLK_FIXED) [*4]
		|-> cnt_clk[0] != $past(cnt_clk[0]))
		else $error("fixed clock tick does not alternate");

	AST_CLK_RSVD: assert property (
		ctrl_r[4].clk_sel == tc_ctrl_pkg::CLK_RSVD |=> !cnt_clk[4])
		else $error("reserved clock code produced a clock");

	AST_IRQ_LEVEL: assert property (
		irq == $past(|(int_st_r & int_en_r)))
		else $error("interrupt does not follow pending status");

	AST_RD_IDLE: assert property (
		!reg_rd |=> reg_rdata == tc_ctrl_pkg::RDATA_RST)
		else $error("read data present without a read strobe");

	COV_EDGE_IRQ: cover property (co_rise[0] ##1 int_st_r[0] ##1 irq);
	COV_CLEAR_RACE: cover property (wr_int && (st_clr & co_rise) != 6'h00);
	COV_GATE_CB: cover property (ctrl_r[3].gate_sel == tc_ctrl_pkg::GATE_CB_BASE && cnt_gate[3]);
	COV_INT_READ: cover property (reg_rd && reg_addr == tc_ctrl_pkg::OFS_INT ##1 reg_rdata != 16'h0000);

endmodule

// [verilog/tc_ctrl_pkg.sv]
// Constants, field layouts and carrier types of the counter gate/clock control block
package tc_ctrl_pkg;

	// Channel set: 0..2 are counter_group1_ch0..2, 3..5 are counter_group2_ch0..2
	localparam int NUM_CH = 6;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// Register offsets as printed, byte addressed, 16-bit registers
	localparam logic [ADDR_W-1:0] OFS_ID      = 8'h80;
	localparam logic [ADDR_W-1:0] OFS_INT     = 8'h82;
	localparam logic [ADDR_W-1:0] OFS_CTRL_A0 = 8'h84;
	localparam logic [ADDR_W-1:0] OFS_CTRL_A1 = 8'h86;
	localparam logic [ADDR_W-1:0] OFS_CTRL_A2 = 8'h88;
	localparam logic [ADDR_W-1:0] OFS_CTRL_B0 = 8'h8A;
	localparam logic [ADDR_W-1:0] OFS_CTRL_B1 = 8'h8C;
	localparam logic [ADDR_W-1:0] OFS_CTRL_B2 = 8'h8E;

	// Identification code, value arbitrary
	localparam logic [DATA_W-1:0] ID_CODE = 16'h5A3C;

	// Interrupt register field positions
	localparam int ST_LSB = 8;
	localparam int EN_LSB = 0;

	// Reset values
	localparam logic [NUM_CH-1:0] INT_EN_RST = 6'h00;
	localparam logic [NUM_CH-1:0] INT_ST_RST = 6'h00;
	localparam logic [DATA_W-1:0] RDATA_RST  = 16'h0000;

	// Gate select codes
	localparam logic [4:0] GATE_LOW     = 5'h00;
	localparam logic [4:0] GATE_HIGH    = 5'h01;
	localparam logic [4:0] GATE_CB_BASE = 5'h02;
	localparam logic [4:0] GATE_P2_BASE = 5'h10;

	// Clock select codes
	localparam logic [3:0] CLK_FIXED    = 4'h0;
	localparam logic [3:0] CLK_RSVD     = 4'h1;

	// Fixed count clock derived from the reference clock
	localparam int REF_CLK_HZ = 10_000_000;
	localparam int FIXED_HZ   = 5_000_000;
	localparam int TICK_DIV   = REF_CLK_HZ / FIXED_HZ;
	localparam int TICK_W     = 2;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
	localparam logic [TICK_W-1:0] TICK_ZERO = 2'h0;

	// Per-channel control register layout
	typedef struct packed {
		logic [2:0] rsv_hi;
		logic [4:0] gate_sel;
		logic [3:0] rsv_lo;
		logic [3:0] clk_sel;
	} ctrl_t;

	localparam ctrl_t CTRL_RST = 16'h0000;

endpackage

// [tb/tb_counter_gate_clock_select_irq.sv]
// Self-checking testbench of the counter gate/clock select and interrupt block
`timescale 1ns/1ns

module tb_counter_gate_clock_select_irq;
	logic                             ref_clk = 1'b0;
	logic                             rst_n = 1'b0;
	logic [tc_ctrl_pkg::ADDR_W-1:0]   reg_addr = 8'h00;
	logic [tc_ctrl_pkg::DATA_W-1:0]   reg_wdata = 16'h0000;
	logic                             reg_wr = 1'b0;
	logic                             reg_rd = 1'b0;
	logic [tc_ctrl_pkg::DATA_W-1:0]   reg_rdata;
	logic [15:0]                      port2_in = 16'h0000;
	logic [15:0]                      clock_bus = 16'h0000;
	logic [tc_ctrl_pkg::NUM_CH-1:0]   cnt_out = 6'h00;
	logic [tc_ctrl_pkg::NUM_CH-1:0]   cnt_gate;
	logic [tc_ctrl_pkg::NUM_CH-1:0]   cnt_clk;
	logic                             irq;
	int                               errors = 0;
	int                               check_count = 0;
	int                               cycles = 0;
	int                               n;
	logic [15:0]                      d;
	// Rows: address, write data, read-back
	logic [47:0]                      rows [11] = '{
		48'h0084_FFFF_1F0F, 48'h0086_FFFF_1F0F, 48'h0088_A5A5_0505,
		48'h008A_1234_1204, 48'h008C_0E0E_0E0E, 48'h008E_1F01_1F01,
		48'h0080_FFFF_5A3C, 48'h0082_003F_003F, 48'h0090_FFFF_0000,
		48'h0083_FFFF_0000, 48'h0082_0000_0000};

	counter_gate_clock_select_irq dut_u
	(
		.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port2_in(port2_in),
		.clock_bus(clock_bus), .cnt_out(cnt_out), .cnt_gate(cnt_gate),
		.cnt_clk(cnt_clk), .irq(irq)
	);

	initial
	begin
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic end_of_test();
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Limit sized well above the longest sequence
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= v;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		op(1'b1, 1'b0, a, v);
		op(1'b0, 1'b0, a, v);
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		op(1'b0, 1'b1, a, 16'h0000);
		op(1'b0, 1'b0, a, 16'h0000);
		@(negedge ref_clk);
		d = reg_rdata;
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic ev(input int ch);
		@(posedge ref_clk);
		cnt_out[ch] <= 1'b1;
		wt(2);
		@(posedge ref_clk);
		cnt_out[ch] <= 1'b0;
		wt(5);
	endtask

	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			rd(8'h82 + 8'(2 * i));
			chk(d, 16'h0000);
		end
		for (int i = 0; i < 11; i++)
		begin
			wr(rows[i][39:32], rows[i][31:16]);
			rd(rows[i][39:32]);
			chk(d, rows[i][15:0]);
		end
		for (int ch = 0; ch < 6; ch++)
		begin
			for (int c = 0; c < 32; c++)
			begin
				wr(8'h84 + 8'(2 * ch), 16'(c) << 8);
				@(posedge ref_clk);
				port2_in <= (c >= 16) ? 16'h0001 << (c - 16) : 16'h0000;
				clock_bus <= (c >= 2 && c < 16) ? 16'h0001 << c : 16'h0000;
				wt(4);
				chk(cnt_gate[ch], c != 0);
				@(posedge ref_clk);
				port2_in <= ~port2_in;
				clock_bus <= ~clock_bus;
				wt(4);
				chk(cnt_gate[ch], c == 1);
			end
			// Code 1 is given bus line 1 too, so a leak shows
			for (int c = 1; c < 16; c++)
			begin
				wr(8'h84 + 8'(2 * ch), 16'(c));
				@(posedge ref_clk);
				clock_bus <= 16'h0001 << c;
				wt(4);
				chk(cnt_clk[ch], c != 1);
				@(posedge ref_clk);
				clock_bus <= ~clock_bus;
				wt(4);
				chk(cnt_clk[ch], 16'h0000);
			end
			wr(8'h84 + 8'(2 * ch), 16'h0000);
			wt(4);
			n = 0;
			repeat (8)
			begin
				n += cnt_clk[ch];
				wt(1);
			end
			chk(16'(n), 16'h0004);
		end
		for (int ch = 0; ch < 6; ch++)
		begin
			wr(8'h82, 16'h003F);
			ev(ch);
			rd(8'h82);
			chk(d, 16'h003F | (16'h0100 << ch));
			chk(irq, 16'h0001);
			wr(8'h82, (16'h0100 << ch) | 16'h003F);
			wt(2);
			chk(irq, 16'h0000);
		end
		wr(8'h82, 16'h0001);
		ev(0);
		ev(5);
		chk(irq, 16'h0001);
		op(1'b1, 1'b0, 8'h82, 16'h0101);
		op(1'b0, 1'b1, 8'h82, 16'h0000);
		op(1'b0, 1'b0, 8'h82, 16'h0000);
		@(negedge ref_clk);
		chk(reg_rdata, 16'h2001);
		wt(2);
		chk(irq, 16'h0000);
		wr(8'h82, 16'h0020);
		wt(2);
		chk(irq, 16'h0001);
		wr(8'h82, 16'h3F00);
		wt(2);
		chk(irq, 16'h0000);
		// Level held high must not set the bit again
		@(posedge ref_clk);
		cnt_out[1] <= 1'b1;
		wt(5);
		wr(8'h82, 16'h0200);
		wt(5);
		rd(8'h82);
		chk(d, 16'h0000);
		@(posedge ref_clk);
		cnt_out[1] <= 1'b0;
		wt(5);
		rd(8'h82);
		chk(d, 16'h0000);
		wr(8'h8E, 16'h1F0F);
		wr(8'h82, 16'h003F);
		ev(2);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		wt(2);
		chk(irq, 16'h0000);
		chk(cnt_gate, 16'h0000);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		rd(8'h8E);
		chk(d, 16'h0000);
		rd(8'h82);
		chk(d, 16'h0000);
		end_of_test();
	end
endmodule
